/* logic/pwu_pkg.sv */
// Package of the periodic wake-up and reset timer: register map,
// field positions, reset values, timing counts and carrier types.
// Assumes a single 10 MHz bus clock and an APB register port.
package pwu_pkg;

  // Register indices; byte address is four times the index
  localparam logic [5:0] PWU_IDX_FLAGS = 6'h1B;
  localparam logic [5:0] PWU_IDX_DIV = 6'h1C;
  localparam logic [5:0] PWU_IDX_WUT = 6'h1D;
  localparam logic [5:0] PWU_IDX_RESET_COUNT_SETTING = 6'h1E;
  localparam logic [5:0] PWU_IDX_CSTAT = 6'h1F;
  localparam logic [5:0] PWU_IDX_MASK = 6'h20;

  // Fields of the flag register and of the mask register
  localparam int PWU_BIT_WUF = 7;
  localparam int PWU_BIT_WUF_ACK = 6;
  localparam int PWU_BIT_PRF = 4;
  localparam int PWU_BIT_PRF_ACK = 3;

  // Reset values and the forced divider value
  localparam logic [7:0] PWU_DIV_RST = 8'h1F;
  localparam logic [7:0] PWU_WUT_RST = 8'hFF;
  localparam logic [7:0] PWU_RESET_COUNT_SETTING_RST = 8'hFF;
  localparam logic [7:0] PWU_DIV_FORCED = 8'hFF;
  localparam logic [7:0] PWU_MASK_RST = 8'h00;

  // Wake-up clock period: base plus step times the divider setting
  localparam logic [12:0] PWU_WCLK_BASE = 13'h01F8;
  localparam logic [12:0] PWU_WCLK_STEP = 13'h0010;

  // Timing: bus clock and nominal low-frequency oscillator rates
  localparam int PWU_CLK_HZ = 10_000_000;
  localparam int PWU_LFO_HZ = 1_000;
  localparam int PWU_LFO_CYCLES = PWU_CLK_HZ / PWU_LFO_HZ;

  typedef struct packed {
    logic [7:0] divider_setting;
    logic [7:0] wakeup_count_setting;
    logic [7:0] reset_count_setting;
  } pwu_cfg_t;

  typedef struct packed {
    logic wakeup_flag;
    logic periodic_reset_flag;
  } pwu_flags_t;

endpackage

/* logic/pwu_wclk_div.sv */
// Wake-up clock divider: turns oscillator tick enables into one
// wake-up clock enable pulse every 504 + 16 * divider ticks.
// Assumes lfo_tick is a one-cycle enable in the pclk domain.
`timescale 1ns/10ps
`default_nettype none
module pwu_wclk_div
  import pwu_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic lfo_tick,
  input wire logic [7:0] divider_setting,
  input wire logic restart,
  output logic wclk_tick
);

  logic [12:0] cnt_q;
  logic [12:0] period;
  logic last;

  // 504 + 16 * setting, at most 4584, fits 13 bits
  assign period = PWU_WCLK_BASE + (PWU_WCLK_STEP * {5'h00, divider_setting});
  assign last = (cnt_q + 13'h0001) >= period;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 13'h0000;
    end else if (restart) begin
      cnt_q <= 13'h0000;
    end else if (lfo_tick) begin
      cnt_q <= last ? 13'h0000 : cnt_q + 13'h0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wclk_tick <= 1'b0;
    end else begin
      wclk_tick <= lfo_tick & last & !restart;
    end
  end

endmodule // pwu_wclk_div
`default_nettype wire

/* logic/pwu_timer.sv */
// Periodic wake-up and reset timer with an APB register port.
// Assumes one 10 MHz clock; the oscillator rate is made by a divider
// enable, and all bus inputs are synchronous to pclk.
//
// Added by the designer: the APB register port.
`timescale 1ns/10ps
`default_nettype none

// Operation
// - Wake-up clock is the oscillator divided by an 8-bit setting, 00 to FF.
// - Wake-up clock period is 504 plus 16 times setting oscillator cycles.
// - Divider setting reads back the value last written, or FF once forced.
// - Divider setting resets to 1F, one second at 1 kHz.
// - Wake-up interrupt after wake-up count setting wake-up clocks elapse.
// - Changing wake-up count restarts its timeout; same value leaves it.
// - Accepted zero wake-up count disables interrupt, forces divider to FF.
// - Zero wake-up count write ignored while reset count is zero.
// - Wake-up count presets to FF on every reset, own reset too.
// - Periodic reset after reset count setting wake-up timeouts.
// - Changing reset count restarts its timeout; same value leaves it.
// - Zero reset count disables periodic reset if wake-up count nonzero.
// - Zero reset count write rejected while wake-up count is zero.
// - Reset count presets to FF on every reset, own reset too.
// - Wake-up flag set on interrupt, cleared by ack, kept on own reset.
// - Reset flag set on periodic reset, cleared by ack, survives it.
// - Oscillator and timer always run; no software can stop them.
module pwu_timer
  import pwu_pkg::*;
#(
  parameter int LFO_CYCLES = pwu_pkg::PWU_LFO_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic wakeup_irq,
  output logic irq,
  output logic periodic_reset
);

  import pwu_pkg::*;

  pwu_cfg_t cfg_q;
  pwu_flags_t flags_q;
  pwu_flags_t mask_q;
  logic [13:0] lfo_cnt_q;
  logic lfo_tick_q;
  logic wclk_tick;
  logic [7:0] wk_cnt_q;
  logic [7:0] rs_cnt_q;
  logic [31:0] prdata_q;
  logic pslverr_q;
  logic periodic_reset_q;
  logic wake_timeout;
  logic wake_evt;
  logic reset_count_setting_evt;
  logic wr;
  logic rd_setup;
  logic [5:0] idx;
  logic [7:0] wdat;
  logic wr_div;
  logic wr_wut;
  logic wr_reset_count_setting;
  logic wut_accept;
  logic reset_count_setting_accept;
  logic wut_change;
  logic reset_count_setting_change;
  logic div_restart;

  // Register index from a byte address; 6'h3F marks a misaligned one or one above 8'hFF
  function automatic logic [5:0] reg_index(input logic [11:0] a);
    if (a[1:0] != 2'b00 || a[11:8] != 4'h0) begin
      return 6'h3F;
    end
    return a[7:2];
  endfunction

  function automatic logic is_mapped(input logic [5:0] i);
    return (i >= PWU_IDX_FLAGS) && (i <= PWU_IDX_MASK);
  endfunction

  assign idx = reg_index(paddr);
  assign wdat = pwdata[7:0];
  assign wr = psel & penable & pwrite & is_mapped(idx);
  assign rd_setup = psel & !penable;
  assign wr_div = wr && idx == PWU_IDX_DIV;
  assign wr_wut = wr && idx == PWU_IDX_WUT;
  assign wr_reset_count_setting = wr && idx == PWU_IDX_RESET_COUNT_SETTING;

  // Interlock: never let both counts become zero
  assign wut_accept = wr_wut &&
    !(wdat == 8'h00 && cfg_q.reset_count_setting == 8'h00);
  assign reset_count_setting_accept = wr_reset_count_setting &&
    !(wdat == 8'h00 && cfg_q.wakeup_count_setting == 8'h00);
  assign wut_change = wut_accept && wdat != cfg_q.wakeup_count_setting;
  assign reset_count_setting_change = reset_count_setting_accept && wdat != cfg_q.reset_count_setting;

  // Oscillator tick enable; free running with no way to stop it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lfo_cnt_q <= 14'h0000;
      lfo_tick_q <= 1'b0;
    end else if (lfo_cnt_q >= 14'(LFO_CYCLES - 1)) begin
      lfo_cnt_q <= 14'h0000;
      lfo_tick_q <= 1'b1;
    end else begin
      lfo_cnt_q <= lfo_cnt_q + 14'h0001;
      lfo_tick_q <= 1'b0;
    end
  end

  // Restart the wake-up clock when its own timer restarts
  assign div_restart = reset_count_setting_evt | wut_change;

  pwu_wclk_div u_wclk_div (
    .pclk(pclk),
    .presetn(presetn),
    .lfo_tick(lfo_tick_q),
    .divider_setting(cfg_q.divider_setting),
    .restart(div_restart),
    .wclk_tick(wclk_tick)
  );

  // Wake-up timeout; a zero count runs 256 clocks with no interrupt
  assign wake_timeout = wclk_tick && !wut_change &&
    ({1'b0, wk_cnt_q} + 9'h001) ==
    ((cfg_q.wakeup_count_setting == 8'h00) ? 9'h100
      : {1'b0, cfg_q.wakeup_count_setting});
  assign wake_evt = wake_timeout &&
    cfg_q.wakeup_count_setting != 8'h00;
  assign reset_count_setting_evt = wake_timeout && !reset_count_setting_change &&
    cfg_q.reset_count_setting != 8'h00 &&
    (rs_cnt_q + 8'h01) == cfg_q.reset_count_setting;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wk_cnt_q <= 8'h00;
    end else if (reset_count_setting_evt || wut_change || wake_timeout) begin
      wk_cnt_q <= 8'h00;
    end else if (wclk_tick) begin
      wk_cnt_q <= wk_cnt_q + 8'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rs_cnt_q <= 8'h00;
    end else if (reset_count_setting_evt || reset_count_setting_change) begin
      rs_cnt_q <= 8'h00;
    end else if (wake_timeout) begin
      rs_cnt_q <= rs_cnt_q + 8'h01;
    end
  end

  // Settings are whole-byte registers in the one clock domain
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q.divider_setting <= PWU_DIV_RST;
    end else if (wut_accept && wdat == 8'h00) begin
      cfg_q.divider_setting <= PWU_DIV_FORCED;
    end else if (wr_div) begin
      cfg_q.divider_setting <= wdat;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q.wakeup_count_setting <= PWU_WUT_RST;
    end else if (reset_count_setting_evt) begin
      cfg_q.wakeup_count_setting <= PWU_WUT_RST;
    end else if (wut_accept) begin
      cfg_q.wakeup_count_setting <= wdat;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q.reset_count_setting <= PWU_RESET_COUNT_SETTING_RST;
    end else if (reset_count_setting_evt) begin
      cfg_q.reset_count_setting <= PWU_RESET_COUNT_SETTING_RST;
    end else if (reset_count_setting_accept) begin
      cfg_q.reset_count_setting <= wdat;
    end
  end

  // Sticky flags: an event wins over an acknowledge in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_q <= '0;
    end else begin
      if (wake_evt) begin
        flags_q.wakeup_flag <= 1'b1;
      end else if (wr && idx == PWU_IDX_FLAGS && wdat[PWU_BIT_WUF_ACK]) begin
        flags_q.wakeup_flag <= 1'b0;
      end
      if (reset_count_setting_evt) begin
        flags_q.periodic_reset_flag <= 1'b1;
      end else if (wr && idx == PWU_IDX_FLAGS && wdat[PWU_BIT_PRF_ACK]) begin
        flags_q.periodic_reset_flag <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_q <= '0;
    end else if (wr && idx == PWU_IDX_MASK) begin
      mask_q.wakeup_flag <= wdat[PWU_BIT_WUF];
      mask_q.periodic_reset_flag <= wdat[PWU_BIT_PRF];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      periodic_reset_q <= 1'b0;
    end else begin
      periodic_reset_q <= reset_count_setting_evt;
    end
  end

  // Read data captured in the setup phase, held through access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (rd_setup) begin
      pslverr_q <= !is_mapped(idx);
      prdata_q <= 32'h0000_0000;
      if (!pwrite) begin
        unique case (idx)
          PWU_IDX_FLAGS: begin
            prdata_q[PWU_BIT_WUF] <= flags_q.wakeup_flag;
            prdata_q[PWU_BIT_PRF] <= flags_q.periodic_reset_flag;
          end
          PWU_IDX_DIV: prdata_q[7:0] <= cfg_q.divider_setting;
          PWU_IDX_WUT: prdata_q[7:0] <= cfg_q.wakeup_count_setting;
          PWU_IDX_RESET_COUNT_SETTING: prdata_q[7:0] <= cfg_q.reset_count_setting;
          PWU_IDX_CSTAT: prdata_q[7:0] <= wk_cnt_q;
          PWU_IDX_MASK: begin
            prdata_q[PWU_BIT_WUF] <= mask_q.wakeup_flag;
            prdata_q[PWU_BIT_PRF] <= mask_q.periodic_reset_flag;
          end
          default: prdata_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign prdata = prdata_q;
  assign pready = 1'b1;
  assign pslverr = psel & penable & pslverr_q;
  assign wakeup_irq = flags_q.wakeup_flag;
  assign irq = |(flags_q & mask_q);
  assign periodic_reset = periodic_reset_q;

endmodule // pwu_timer
`default_nettype wire

/* verif/pwu_timer_chk.sv */
// Port checker of the wake-up and reset timer.
// Assumes binding to pwu_timer; watches its ports only.
`timescale 1ns/10ps
`default_nettype none
module pwu_timer_chk #(
  parameter int LFO_CYCLES = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic wakeup_irq,
  input wire logic irq,
  input wire logic periodic_reset
);
  logic [15:0] gap_q;
  logic ack;
  logic mapped;
  assign ack = psel && penable && pwrite && paddr == 12'h06C && pwdata[6];
  assign mapped = paddr inside {12'h06C, 12'h070, 12'h074, 12'h078,
    12'h07C, 12'h080};
  // Cycles since the last periodic reset, saturating
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) gap_q <= 16'hFFFF;
    else if (periodic_reset) gap_q <= 16'h0000;
    else if (gap_q != 16'hFFFF) gap_q <= gap_q + 16'h0001;
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  rst_pulse_a: assert property (periodic_reset |=> !periodic_reset)
    else $error("periodic reset pulse too long");
  rst_gap_a: assert property (periodic_reset |-> gap_q >= 16'(504 * LFO_CYCLES))
    else $error("periodic resets too close");
  wake_hold_a: assert property (wakeup_irq && !ack |=> wakeup_irq)
    else $error("wake-up request dropped");
  wake_ack_a: assert property (wakeup_irq && ack |=> !wakeup_irq)
    else $error("wake-up flag not cleared");
  wake_keep_a: assert property (periodic_reset && !ack |=> wakeup_irq == $past(wakeup_irq))
    else $error("wake-up flag lost at periodic reset");
  bad_addr_a: assert property (psel && penable && !mapped |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  good_addr_a: assert property (psel && penable && mapped |-> !pslverr)
    else $error("mapped access refused");
  rd_upper_a: assert property (psel && penable && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("read data upper bits set");
endmodule // pwu_timer_chk
`default_nettype wire

/* verif/pwu_core_model.sv */
// Core side model: counts wake-up requests and system reset pulses.
// Assumes the timer's event outputs are in the pclk domain.
`timescale 1ns/10ps
`default_nettype none
module pwu_core_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic wakeup_irq,
  input wire logic periodic_reset,
  output logic [7:0] rst_seen,
  output logic [7:0] wake_seen
);
  logic wake_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_seen <= 8'h00;
      wake_seen <= 8'h00;
      wake_q <= 1'b0;
    end else begin
      wake_q <= wakeup_irq;
      if (wakeup_irq && !wake_q) wake_seen <= wake_seen + 8'h01;
      if (periodic_reset) rst_seen <= rst_seen + 8'h01;
    end
  end
endmodule // pwu_core_model
`default_nettype wire

/* verif/pwu_timer_tb.sv */
// Testbench of the timer: registers, interlocks and event timing.
// Assumes the checker and the core model are compiled first.
`timescale 1ns/10ps
`default_nettype none
module pwu_timer_tb;
  import pwu_pkg::*;
  localparam int LOW_FREQ_OSC = 4;
  localparam int WAKE = 504 * LOW_FREQ_OSC;
  localparam logic [11:0] A_FLG = 12'h06C, A_DIV = 12'h070, A_WK = 12'h074;
  localparam logic [11:0] A_RC = 12'h078, A_MSK = 12'h080;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, wakeup_irq, irq, periodic_reset;
  logic [7:0] rst_seen, wake_seen, v;
  logic [32:0] exp_q[$];
  int err_count = 0, tests_run = 0, n;
  always #50 pclk = ~pclk;
  pwu_timer #(.LFO_CYCLES(LOW_FREQ_OSC)) i_dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .wakeup_irq(wakeup_irq), .irq(irq), .periodic_reset(periodic_reset));
  pwu_core_model i_core (.pclk(pclk), .presetn(presetn),
    .wakeup_irq(wakeup_irq), .periodic_reset(periodic_reset),
    .rst_seen(rst_seen), .wake_seen(wake_seen));
  task check(input logic [32:0] got, input logic [32:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask
  task rd(input logic [11:0] a, input logic [7:0] d);
    exp_q.push_back({9'h0, 24'h0, d});
    apb(1'b0, a, 32'h0);
  endtask
  task wait_ev(input logic rst, output int k);
    k = 0;
    while (!(rst ? rst_seen != 8'h00 : wakeup_irq === 1'b1) && k < 3 * WAKE) begin
      @(negedge pclk);
      k++;
    end
    @(posedge pclk);
  endtask
  task stop_test;
    $display("tests_run=%0d err_count=%0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Read results compared against the oldest note
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite) check({pslverr, prdata}, exp_q.pop_front());
  end
  initial begin
    #2_000_000;
    err_count++;
    stop_test;
  end
  initial begin
    void'($urandom(32'h2343C11C));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(A_DIV, 8'h1F);
    rd(A_WK, 8'hFF);
    rd(A_RC, 8'hFF);
    exp_q.push_back({1'b1, 32'h0});
    apb(1'b0, 12'h06D, 32'h0);
    $display("test reset values done");
    for (int i = 0; i < 6; i++) begin
      v = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($urandom);
      wr(A_DIV, v);
      rd(A_DIV, v);
    end
    $display("test divider readback done");
    wr(A_RC, 8'h00);
    rd(A_RC, 8'h00);
    wr(A_WK, 8'h00);
    rd(A_WK, 8'hFF);
    wr(A_RC, 8'h02);
    wr(A_WK, 8'h00);
    rd(A_WK, 8'h00);
    rd(A_DIV, 8'hFF);
    wr(A_RC, 8'h00);
    rd(A_RC, 8'h02);
    $display("test interlocks done");
    wr(A_DIV, 8'h00);
    wr(A_MSK, 8'h90);
    wr(A_WK, 8'h01);
    wait_ev(1'b0, n);
    check(33'(n > WAKE - 16 && n < WAKE + 16), 33'h1);
    check(33'(irq), 33'h1);
    wr(A_MSK, 8'h00);
    check(33'(irq), 33'h0);
    wr(A_FLG, 8'h40);
    check(33'(wakeup_irq), 33'h0);
    wait_ev(1'b1, n);
    check(33'(rst_seen), 33'h1);
    check(33'(wake_seen), 33'h2);
    check(33'(wakeup_irq), 33'h1);
    rd(A_WK, 8'hFF);
    rd(A_RC, 8'hFF);
    rd(A_DIV, 8'h00);
    $display("test periodic reset done");
    wr(A_FLG, 8'h40);
    wr(A_WK, 8'h01);
    repeat (1000) @(posedge pclk);
    wr(A_WK, 8'h01);
    wait_ev(1'b0, n);
    check(33'(n + 1004 > WAKE - 16 && n + 1004 < WAKE + 16), 33'h1);
    $display("test same value write done");
    stop_test;
  end
endmodule // pwu_timer_tb
bind pwu_timer pwu_timer_chk #(.LFO_CYCLES(LFO_CYCLES)) i_chk (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .wakeup_irq(wakeup_irq), .irq(irq),
  .periodic_reset(periodic_reset));
`default_nettype wire
